// ==== two_wire_pkg.sv ====
// Shared constants and types for the two-wire serial register link.
package two_wire_pkg;

    // Controller timing: serial clock built from the system clock.
    localparam int unsigned CLOCK_HZ        = 40_000_000;
    localparam int unsigned SCL_RATE_HZ     = 400_000;
    localparam int unsigned SCL_QUARTER_CYC = CLOCK_HZ / (4 * SCL_RATE_HZ);

    // Target addressing: 7-bit form of 0x20/0x21, one step per select code.
    localparam logic [6:0] TARGET_BASE_ADDR = 7'h10;
    localparam logic [6:0] TARGET_ADDR_STEP = 7'h08;
    localparam logic       DIR_WRITE        = 1'b0;
    localparam logic       DIR_READ         = 1'b1;

    // Byte and register address layout.
    localparam int         DATA_W     = 8;
    localparam int         REG_ADDR_W = 16;
    localparam logic [2:0] BIT_LAST   = 3'h7;
    localparam logic [3:0] ACK_SLOT   = 4'h8;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [7:0] MEM_RESET  = 8'h00;

    // Controller operations.
    typedef enum logic [1:0] {
        OP_WRITE        = 2'h0,
        OP_READ_RANDOM  = 2'h1,
        OP_READ_CURRENT = 2'h2
    } op_t;

    // Controller symbols on the line.
    typedef enum logic [2:0] {
        SYM_START = 3'h0,
        SYM_TX    = 3'h1,
        SYM_RX    = 3'h2,
        SYM_STOP  = 3'h3,
        SYM_END   = 3'h4
    } sym_t;

    // Target protocol states, Gray coded along the write path.
    typedef enum logic [2:0] {
        T_IDLE   = 3'b000,
        T_ADDR   = 3'b001,
        T_ACK    = 3'b011,
        T_RX     = 3'b010,
        T_TX     = 3'b110,
        T_TACK   = 3'b111,
        T_IGNORE = 3'b101
    } tstate_t;

    // Controller states.
    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_RUN  = 2'b01
    } cstate_t;

endpackage

// ==== two_wire_if.sv ====
// Two-wire link between controller and target, with open-drain data resolution.
interface two_wire_if;
    logic serial_clock_line;
    logic controller_sda_out;
    logic controller_sda_oe_n;
    logic target_sda_out;
    logic target_sda_oe_n;
    logic serial_data_line;

    // Pull-up: the line is low only while an enabled driver outputs low.
    assign serial_data_line = (controller_sda_oe_n | controller_sda_out) & (target_sda_oe_n | target_sda_out);

    modport controller (
        output serial_clock_line,
        output controller_sda_out,
        output controller_sda_oe_n,
        input  serial_data_line
    );

    modport target (
        input  serial_clock_line,
        input  serial_data_line,
        output target_sda_out,
        output target_sda_oe_n
    );
endinterface

// ==== sync_2ff.sv ====
// Two-flop synchroniser for signals entering a clock domain.
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // Clock.
    input  wire logic             i_clock,
    // Asynchronous data in, synchronised data out.
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    // The first stage is read only by the second stage.
    always_ff @(posedge i_clock) begin
        meta_r <= i_async;
        o_sync <= meta_r;
    end
endmodule

// ==== two_wire_target.sv ====
// Target end: serial register slave with a small register array.
module two_wire_target
    import two_wire_pkg::*;
#(
    parameter int MEM_DEPTH = 16
) (
    // Link side.
    two_wire_if.target              bus,
    input  wire logic               i_master_input_clock,
    input  wire logic               i_rst_n,
    input  wire logic [2:0]         i_bus_address_select,
    // User side, on the system clock.
    input  wire logic               i_clock,
    input  wire logic               i_srst,
    output logic                    o_wr_valid,
    output logic [REG_ADDR_W-1:0]   o_wr_addr,
    output logic [DATA_W-1:0]       o_wr_data
);
    localparam int IDX_W = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

    logic                  scl_s;
    logic                  sda_s;
    logic [2:0]            sel_s;
    logic                  scl_q_r;
    logic                  sda_q_r;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_det;
    logic                  stop_det;
    logic [6:0]            own_addr;
    tstate_t               state_r;
    logic [2:0]            bit_cnt_r;
    logic                  byte_full_r;
    logic [DATA_W-1:0]     shift_r;
    logic                  is_read_r;
    logic [1:0]            byte_idx_r;
    logic [REG_ADDR_W-1:0] ptr_r;
    logic                  sda_oe_n_r;
    logic [DATA_W-1:0]     mem [MEM_DEPTH];
    logic [DATA_W-1:0]     mem_rd;
    logic                  wr_stb;
    logic                  wr_tgl_r;
    logic [REG_ADDR_W-1:0] hold_addr_r;
    logic [DATA_W-1:0]     hold_data_r;
    logic                  tgl_s;
    logic                  tgl_q_r;

    // Bring clock, data and the select straps into the link domain.
    sync_2ff #(.WIDTH(5)) u_pin_sync (
        .i_clock (i_master_input_clock),
        .i_async ({i_bus_address_select, bus.serial_clock_line, bus.serial_data_line}),
        .o_sync  ({sel_s, scl_s, sda_s})
    );

    // Previous samples for edge and condition detection; idle is both high.
    always_ff @(posedge i_master_input_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    // Line events; data changes while the clock is high are conditions, not bits.
    assign scl_rise  = scl_s & ~scl_q_r;
    assign scl_fall  = ~scl_s & scl_q_r;
    assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
    assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;

    // Own address from the select straps: 000 gives 0x20/0x21, 001 gives 0x30/0x31.
    assign own_addr = TARGET_BASE_ADDR + (TARGET_ADDR_STEP * {4'h0, sel_s});

    // Register read port at the pointer, and the write strobe for data bytes.
    assign mem_rd = mem[ptr_r[IDX_W-1:0]];
    assign wr_stb = (state_r == T_RX) && scl_fall && byte_full_r && (byte_idx_r == 2'h2);

    // Protocol engine: receives bytes on clock rises, changes the line on clock falls.
    always_ff @(posedge i_master_input_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r     <= T_IDLE;
            bit_cnt_r   <= 3'h0;
            byte_full_r <= 1'b0;
            shift_r     <= 8'h00;
            is_read_r   <= 1'b0;
            byte_idx_r  <= 2'h0;
            ptr_r       <= PTR_RESET;
            sda_oe_n_r  <= 1'b1;
        end else if (start_det) begin
            // A start or restart always opens a fresh address phase.
            state_r     <= T_ADDR;
            bit_cnt_r   <= 3'h0;
            byte_full_r <= 1'b0;
            sda_oe_n_r  <= 1'b1;
        end else if (stop_det) begin
            state_r    <= T_IDLE;
            sda_oe_n_r <= 1'b1;
        end else begin
            case (state_r)
                T_ADDR, T_RX: begin
                    if (scl_rise) begin
                        shift_r   <= {shift_r[DATA_W-2:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == BIT_LAST) begin
                            byte_full_r <= 1'b1;
                        end
                    end else if (scl_fall && byte_full_r) begin
                        byte_full_r <= 1'b0;
                        if (state_r == T_ADDR) begin
                            if (shift_r[7:1] == own_addr) begin
                                sda_oe_n_r <= 1'b0;
                                is_read_r  <= (shift_r[0] == DIR_READ);
                                byte_idx_r <= 2'h0;
                                state_r    <= T_ACK;
                            end else begin
                                state_r <= T_IGNORE;
                            end
                        end else begin
                            // Register address high, then low, then data bytes.
                            sda_oe_n_r <= 1'b0;
                            state_r    <= T_ACK;
                            case (byte_idx_r)
                                2'h0:    ptr_r[15:8] <= shift_r;
                                2'h1:    ptr_r[7:0]  <= shift_r;
                                default: ptr_r       <= ptr_r + 16'h0001;
                            endcase
                            if (byte_idx_r != 2'h2) begin
                                byte_idx_r <= byte_idx_r + 2'h1;
                            end
                        end
                    end
                end
                T_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 3'h0;
                        if (is_read_r) begin
                            // Load the byte at the pointer and present its MSB.
                            shift_r    <= mem_rd;
                            sda_oe_n_r <= mem_rd[7];
                            ptr_r      <= ptr_r + 16'h0001;
                            state_r    <= T_TX;
                        end else begin
                            sda_oe_n_r <= 1'b1;
                            state_r    <= T_RX;
                        end
                    end
                end
                T_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == BIT_LAST) begin
                            sda_oe_n_r <= 1'b1;
                            state_r    <= T_TACK;
                        end else begin
                            bit_cnt_r  <= bit_cnt_r + 3'h1;
                            shift_r    <= {shift_r[DATA_W-2:0], 1'b0};
                            sda_oe_n_r <= shift_r[6];
                        end
                    end
                end
                T_TACK: begin
                    // Acknowledge from the controller sends the next byte; no-acknowledge ends it.
                    if (scl_rise) begin
                        state_r <= sda_s ? T_IGNORE : T_ACK;
                    end
                end
                default: begin
                    sda_oe_n_r <= 1'b1;
                end
            endcase
        end
    end

    // Register array, written by data bytes of a write transaction.
    always_ff @(posedge i_master_input_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= MEM_RESET;
            end
        end else if (wr_stb) begin
            mem[ptr_r[IDX_W-1:0]] <= shift_r;
        end
    end

    // Each stored byte is held and announced by a toggle to the user domain.
    always_ff @(posedge i_master_input_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_tgl_r    <= 1'b0;
            hold_addr_r <= PTR_RESET;
            hold_data_r <= MEM_RESET;
        end else if (wr_stb) begin
            wr_tgl_r    <= ~wr_tgl_r;
            hold_addr_r <= ptr_r;
            hold_data_r <= shift_r;
        end
    end

    // Open-drain data: only ever pulled low; the clock line is never driven.
    assign bus.target_sda_out   = 1'b0;
    assign bus.target_sda_oe_n  = sda_oe_n_r;

    sync_2ff #(.WIDTH(1)) u_tgl_sync (
        .i_clock (i_clock),
        .i_async (wr_tgl_r),
        .o_sync  (tgl_s)
    );

    // User domain: a toggle edge captures the held word, which is stable by then.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            tgl_q_r    <= 1'b0;
            o_wr_valid <= 1'b0;
            o_wr_addr  <= PTR_RESET;
            o_wr_data  <= MEM_RESET;
        end else begin
            tgl_q_r    <= tgl_s;
            o_wr_valid <= tgl_s ^ tgl_q_r;
            if (tgl_s ^ tgl_q_r) begin
                o_wr_addr <= hold_addr_r;
                o_wr_data <= hold_data_r;
            end
        end
    end
endmodule

// ==== two_wire_controller.sv ====
// Controller end: makes the serial clock and runs single-byte register transactions.
module two_wire_controller
    import two_wire_pkg::*;
(
    // Clock and reset.
    input  wire logic                  i_clock,
    input  wire logic                  i_srst,
    // Command port.
    input  wire logic                  i_cmd_valid,
    input  wire op_t                   i_cmd_op,
    input  wire logic [6:0]            i_cmd_target,
    input  wire logic [REG_ADDR_W-1:0] i_cmd_reg_addr,
    input  wire logic [DATA_W-1:0]     i_cmd_wr_data,
    output logic                       o_cmd_ready,
    output logic                       o_done,
    output logic                       o_nack,
    output logic [DATA_W-1:0]          o_rd_data,
    // Link side.
    two_wire_if.controller             bus
);
    localparam logic [7:0] QUARTER_LAST = 8'(SCL_QUARTER_CYC - 1);

    cstate_t               state_r;
    op_t                   op_r;
    logic [6:0]            tgt_r;
    logic [REG_ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0]     data_r;
    logic [7:0]            qcnt_r;
    logic [1:0]            phase_r;
    logic [3:0]            step_r;
    logic [3:0]            bit_r;
    logic [DATA_W-1:0]     rx_r;
    logic                  scl_r;
    logic                  oe_n_r;
    logic                  sda_s;
    logic                  tick;
    logic                  slot_end;
    sym_t                  sym;
    logic [7:0]            tx_byte;
    logic [3:0]            stop_step;

    sync_2ff #(.WIDTH(1)) u_sda_sync (
        .i_clock (i_clock),
        .i_async (bus.serial_data_line),
        .o_sync  (sda_s)
    );

    // Symbol sequence of each operation, the byte sent, and where a stop sits.
    always_comb begin
        sym       = SYM_END;
        tx_byte   = {tgt_r, DIR_WRITE};
        stop_step = 4'h5;
        case (op_r)
            OP_WRITE: begin
                case (step_r)
                    4'h0:                sym = SYM_START;
                    4'h1, 4'h2, 4'h3, 4'h4: sym = SYM_TX;
                    4'h5:                sym = SYM_STOP;
                    default:             sym = SYM_END;
                endcase
            end
            OP_READ_RANDOM: begin
                stop_step = 4'h7;
                case (step_r)
                    4'h0, 4'h4:             sym = SYM_START;
                    4'h1, 4'h2, 4'h3, 4'h5: sym = SYM_TX;
                    4'h6:                   sym = SYM_RX;
                    4'h7:                   sym = SYM_STOP;
                    default:                sym = SYM_END;
                endcase
            end
            default: begin
                stop_step = 4'h3;
                case (step_r)
                    4'h0:    sym = SYM_START;
                    4'h1:    sym = SYM_TX;
                    4'h2:    sym = SYM_RX;
                    4'h3:    sym = SYM_STOP;
                    default: sym = SYM_END;
                endcase
            end
        endcase
        case (step_r)
            4'h1:    tx_byte = {tgt_r, (op_r == OP_READ_CURRENT) ? DIR_READ : DIR_WRITE};
            4'h2:    tx_byte = addr_r[15:8];
            4'h3:    tx_byte = addr_r[7:0];
            4'h4:    tx_byte = data_r;
            default: tx_byte = {tgt_r, DIR_READ};
        endcase
    end

    assign tick        = (qcnt_r == QUARTER_LAST);
    assign slot_end    = tick && (phase_r == 2'h3);
    assign o_cmd_ready = (state_r == C_IDLE);

    // Sequencer: quarter-period ticks walk phases, bits, and symbols.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_r   <= C_IDLE;
            op_r      <= OP_WRITE;
            tgt_r     <= 7'h00;
            addr_r    <= PTR_RESET;
            data_r    <= MEM_RESET;
            qcnt_r    <= 8'h00;
            phase_r   <= 2'h0;
            step_r    <= 4'h0;
            bit_r     <= 4'h0;
            rx_r      <= MEM_RESET;
            o_done    <= 1'b0;
            o_nack    <= 1'b0;
            o_rd_data <= MEM_RESET;
        end else begin
            o_done <= 1'b0;
            case (state_r)
                C_IDLE: begin
                    if (i_cmd_valid) begin
                        state_r <= C_RUN;
                        op_r    <= i_cmd_op;
                        tgt_r   <= i_cmd_target;
                        addr_r  <= i_cmd_reg_addr;
                        data_r  <= i_cmd_wr_data;
                        qcnt_r  <= 8'h00;
                        phase_r <= 2'h0;
                        step_r  <= 4'h0;
                        bit_r   <= 4'h0;
                        o_nack  <= 1'b0;
                    end
                end
                C_RUN: begin
                    qcnt_r <= tick ? 8'h00 : qcnt_r + 8'h01;
                    if (tick) begin
                        phase_r <= phase_r + 2'h1;
                    end
                    // Sample the line in the clock-high half of each bit.
                    if (tick && (phase_r == 2'h2)) begin
                        if (sym == SYM_RX && bit_r != ACK_SLOT) begin
                            rx_r <= {rx_r[DATA_W-2:0], sda_s};
                        end
                        if (sym == SYM_TX && bit_r == ACK_SLOT && sda_s) begin
                            o_nack <= 1'b1;
                        end
                    end
                    if (sym == SYM_END) begin
                        state_r <= C_IDLE;
                        o_done  <= 1'b1;
                    end else if (slot_end) begin
                        if (sym == SYM_START || sym == SYM_STOP) begin
                            step_r <= step_r + 4'h1;
                        end else if (bit_r != ACK_SLOT) begin
                            bit_r <= bit_r + 4'h1;
                        end else begin
                            bit_r <= 4'h0;
                            if (sym == SYM_RX) begin
                                o_rd_data <= rx_r;
                            end
                            step_r <= (sym == SYM_TX && o_nack) ? stop_step : step_r + 4'h1;
                        end
                    end
                end
                default: state_r <= C_IDLE;
            endcase
        end
    end

    // Line drive: data moves only while the clock is low, except in start and stop.
    always_ff @(posedge i_clock) begin
        if (i_srst || state_r == C_IDLE || sym == SYM_END) begin
            scl_r  <= 1'b1;
            oe_n_r <= 1'b1;
        end else begin
            case (sym)
                SYM_START: begin
                    scl_r  <= (phase_r != 2'h0);
                    oe_n_r <= ~phase_r[1];
                end
                SYM_STOP: begin
                    scl_r  <= (phase_r != 2'h0);
                    oe_n_r <= phase_r[1];
                end
                SYM_TX: begin
                    scl_r  <= phase_r[1];
                    oe_n_r <= (bit_r == ACK_SLOT) ? 1'b1 : tx_byte[3'(7 - bit_r)];
                end
                default: begin
                    // Single-byte read: the acknowledge slot is left high as no-acknowledge.
                    scl_r  <= phase_r[1];
                    oe_n_r <= 1'b1;
                end
            endcase
        end
    end

    assign bus.serial_clock_line   = scl_r;
    assign bus.controller_sda_out  = 1'b0;
    assign bus.controller_sda_oe_n = oe_n_r;
endmodule

// ==== two_wire_link_properties.sv ====
// Checker for the two-wire link signals between controller and target.
module two_wire_link_properties (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_srst,
    // Link signals.
    input wire logic serial_clock_line,
    input wire logic controller_sda_out,
    input wire logic controller_sda_oe_n,
    input wire logic target_sda_out,
    input wire logic target_sda_oe_n,
    input wire logic serial_data_line
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    logic [15:0] run_r;
    // Counts how long the target holds the data line low without a break.
    always_ff @(posedge i_clock) begin
        run_r <= (i_srst || target_sda_oe_n) ? 16'h0000 : run_r + 16'h0001;
    end
    chk_target_pull_only: assert property (!target_sda_oe_n |-> !target_sda_out)
        else $error("target drives data high");
    chk_ctrl_pull_only: assert property (!controller_sda_oe_n |-> !controller_sda_out)
        else $error("controller drives data high");
    // Both ends may pull low together just after a clock fall; only an overlap while the clock is high clashes.
    chk_one_driver: assert property (!target_sda_oe_n && serial_clock_line |-> controller_sda_oe_n)
        else $error("both ends drive data");
    chk_start_by_ctrl: assert property ($fell(serial_data_line) && serial_clock_line
        && $past(serial_clock_line) |-> !controller_sda_oe_n) else $error("data fell by target");
    chk_stop_released: assert property ($rose(serial_data_line) && serial_clock_line
        && $past(serial_clock_line) |-> target_sda_oe_n) else $error("target holds data at stop");
    chk_target_moves_low: assert property ($changed(target_sda_oe_n) |-> !serial_clock_line)
        else $error("target moved data while clock high");
    chk_clock_high_len: assert property ($rose(serial_clock_line) |-> serial_clock_line [*8])
        else $error("clock high phase too short");
    chk_drive_bounded: assert property (run_r <= 16'h03E8)
        else $error("target drives data too long");
    cover property ($fell(target_sda_oe_n));
    cover property ($rose(serial_data_line) && serial_clock_line);
    cover property (run_r == 16'h0190);
endmodule

// ==== two_wire_register_slave_tb_top.sv ====
// Bench joining controller and target over the two-wire link.
module two_wire_register_slave_tb_top import two_wire_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, link_clock = 1'b0, srst = 1'b1, rst_n = 1'b0, valid = 1'b0;
    logic [2:0]  sel = 3'h0;
    op_t         op = OP_WRITE;
    logic [6:0]  tgt = 7'h10;
    logic [15:0] reg_a = 16'h0000, wr_addr, ptr = 16'h0000;
    logic [7:0]  wdat = 8'h00, rd_data, wr_data, mem [16];
    logic        ready, done, nack, wr_valid;
    logic [31:0] seed = 32'hB032;
    int          err_total = 0, checks = 0, wr_cnt = 0, cyc = 0;
    two_wire_if bus_if ();
    two_wire_controller i_two_wire_controller (.i_clock(clock), .i_srst(srst), .i_cmd_valid(valid),
        .i_cmd_op(op), .i_cmd_target(tgt), .i_cmd_reg_addr(reg_a), .i_cmd_wr_data(wdat), .o_cmd_ready(ready),
        .o_done(done), .o_nack(nack), .o_rd_data(rd_data), .bus(bus_if.controller));
    two_wire_target i_two_wire_target (.bus(bus_if.target), .i_master_input_clock(link_clock), .i_rst_n(rst_n),
        .i_bus_address_select(sel), .i_clock(clock), .i_srst(srst), .o_wr_valid(wr_valid),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data));
    two_wire_link_properties i_two_wire_link_properties (.i_clock(clock), .i_srst(srst),
        .serial_clock_line(bus_if.serial_clock_line), .controller_sda_out(bus_if.controller_sda_out),
        .controller_sda_oe_n(bus_if.controller_sda_oe_n), .target_sda_out(bus_if.target_sda_out),
        .target_sda_oe_n(bus_if.target_sda_oe_n), .serial_data_line(bus_if.serial_data_line));
    // The two clocks run at unrelated rates.
    always #12.5 clock = ~clock;
    always #80 link_clock = ~link_clock;
    // Counts stored-write pulses and cuts a hang short.
    always @(posedge clock) begin
        wr_cnt += (wr_valid === 1'b1);
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            complete_run();
        end
    end
    // Steps the random source.
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Tells whether a target address matches the selected one.
    function automatic logic hit(input logic [6:0] t, input logic [2:0] s);
        return t == 7'h10 + {s, 3'h0};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Runs one transaction and compares against the bench's memory model.
    task automatic run(input op_t o, input logic [6:0] t, input logic [15:0] r, input logic [7:0] d);
        int n;
        int w0;
        logic h;
        w0 = wr_cnt;
        h = hit(t, sel);
        check(16'({ready, bus_if.serial_clock_line, bus_if.serial_data_line}), 16'h0007);
        @(negedge clock);
        {valid, op, tgt, reg_a, wdat} = {1'b1, o, t, r, d};
        @(negedge clock);
        valid = 1'b0;
        for (n = 0; done !== 1'b1 && n < 6000; n++) @(negedge clock);
        check(16'(n < 6000), 16'h0001);
        check(16'(nack), 16'(!h));
        check(16'(wr_cnt - w0), 16'(h && o == OP_WRITE));
        if (h && o == OP_WRITE) begin
            mem[r[3:0]] = d;
            ptr = r + 16'h0001;
            check(wr_addr, r);
            check(16'(wr_data), 16'(d));
        end else if (h) begin
            ptr = (o == OP_READ_RANDOM) ? r : ptr;
            check(16'(rd_data), 16'(mem[ptr[3:0]]));
            ptr++;
        end
    endtask
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (8) @(negedge clock);
        srst = 1'b0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        run(OP_READ_CURRENT, 7'h10, 16'h0000, 8'h00);
        run(OP_WRITE, 7'h10, 16'hFFFF, 8'h5A);
        run(OP_READ_CURRENT, 7'h10, 16'h0000, 8'h00);
        run(OP_READ_RANDOM, 7'h10, 16'hFFFF, 8'h00);
        run(OP_WRITE, 7'h18, 16'h0003, 8'hC3);
        sel = 3'h1;
        run(OP_WRITE, 7'h18, 16'h0003, 8'hC3);
        run(OP_READ_RANDOM, 7'h10, 16'h0003, 8'h00);
        run(OP_READ_RANDOM, 7'h18, 16'h0003, 8'h00);
        repeat (8) begin
            seed = xs(seed);
            sel = seed[2:0];
            run(op_t'(seed[5:4] % 3), seed[3] ? 7'h10 + {sel, 3'h0} : seed[14:8], seed[31:16], seed[23:16]);
        end
        complete_run();
    end
endmodule
